// File: verilog/host_dma_port.v
// Host port giving an outside processor access to on-chip program and data memory.
// Assumes host pins are synchronous to clk and memories answer one cycle after a strobe.
//
// Summary of operation
// - Host reads and writes memory, one stolen core cycle per word.
// - Host writes never reach the memory-mapped control register area.
// - Latched word with bit 15 set loads overlay from bits 7:0.
// - Bit 15 clear: bits 13:0 start address, bit 14 selects program memory.
// - One 16-bit shared address/data bus; program words travel as two halves.
// - Host pins sampled directly on clk; host writes accepted while core runs.
// - Address increments after each completed word transfer.
// - Address latched on strobe falling edge or select rising edge.
// - One cycle synchronising the request, one cycle for memory access.
// - Core software writes address and format at the control register.
// - Host cannot read back the latched address.
// - Control bit selects one of two short-read timing variants.
// - Mode C=1, B=0, A=1 at reset selects boot through this port.
// - In host boot mode, core held until program memory location zero is written.
// - Port address register separate from byte-memory DMA registers.
`timescale 1ns/1ns
`include "host_port_map.vh"

module host_dma_port
(
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Host pins
  input  wire        portSelectN,
  input  wire        addrLatchStrobe,
  input  wire        hostReadN,
  input  wire        hostWriteN,
  input  wire [15:0] busIn,
  output reg  [15:0] busOut,
  output wire        busOe,
  output wire        hostAck,
  // Core data memory register access
  input  wire        regWrite,
  input  wire [13:0] regAddr,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  // Internal memory access
  output reg         memStrobe,
  output reg         memWe,
  output reg         memIsPm,
  output reg  [13:0] memAddr,
  output reg  [23:0] memWdata,
  input  wire [23:0] memRdata,
  // Overlay and boot
  output wire [7:0]  overlaySel,
  input  wire [2:0]  bootMode,
  output wire        coreHold
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_SYNC   = 2'h1;
  localparam [1:0] ST_ACCESS = 2'h2;
  localparam [1:0] ST_FINISH = 2'h3;

  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [13:0] addr_q;
  reg        isPm_q;
  reg [7:0]  overlay_q;
  reg        shortRead_q;
  reg        lowHalf_q;
  reg        isRead_q;
  reg [15:0] wrHold_q;
  reg [7:0]  rdLow_q;
  reg        selPrev_q;
  reg        alsPrev_q;
  reg        oeHold_q;
  reg        pmDone_q;
  reg [13:0] pmDoneAddr_q;

  wire request;
  wire latchEv;
  wire rdActive;
  wire wordEnd;
  wire needAccess;

  // Clears the control-region check when the target is program memory.
  function ctrlRegion;
    input        pm;
    input [13:0] a;
    begin
      ctrlRegion = !pm && (a >= `HP_CTRL_REGION_BASE);
    end
  endfunction

  // ****************************************
  // Host strobe decode
  // ****************************************
  // select plus strobe
  assign request  = !portSelectN && (!hostReadN || !hostWriteN);
  assign latchEv  = (alsPrev_q && !addrLatchStrobe && !portSelectN)
                  || (!selPrev_q && portSelectN && addrLatchStrobe);
  assign hostAck  = (state_q == ST_IDLE) || (state_q == ST_FINISH);
  // program words end on the low half
  assign wordEnd  = !isPm_q || lowHalf_q;
  // Reads touch memory on the first half; writes on the last.
  assign needAccess = isRead_q ? (!isPm_q || !lowHalf_q) : wordEnd;

  assign rdActive = (state_q == ST_FINISH) && isRead_q && !portSelectN && !hostReadN;
  assign busOe    = rdActive || (!shortRead_q && oeHold_q);
  assign overlaySel = overlay_q;

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (request && !latchEv)
          state_d = ST_SYNC;
      ST_SYNC:
        state_d = ST_ACCESS;
      ST_ACCESS:
        state_d = ST_FINISH;
      ST_FINISH:
        if (hostReadN && hostWriteN)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q      <= ST_IDLE;
      addr_q       <= `HP_ADDR_RESET;
      isPm_q       <= 1'b0;
      overlay_q    <= `HP_OVL_RESET;
      shortRead_q  <= `HP_SHORT_READ_RESET;
      lowHalf_q    <= 1'b0;
      isRead_q     <= 1'b0;
      wrHold_q     <= 16'h0000;
      rdLow_q      <= 8'h00;
      selPrev_q    <= 1'b1;
      alsPrev_q    <= 1'b0;
      oeHold_q     <= 1'b0;
      busOut       <= 16'h0000;
      memStrobe    <= 1'b0;
      memWe        <= 1'b0;
      memIsPm      <= 1'b0;
      memAddr      <= 14'h0000;
      memWdata     <= 24'h000000;
      pmDone_q     <= 1'b0;
      pmDoneAddr_q <= 14'h0000;
    end
    else
    begin
      state_q   <= state_d;
      selPrev_q <= portSelectN;
      alsPrev_q <= addrLatchStrobe;
      memStrobe <= 1'b0;
      pmDone_q  <= 1'b0;
      oeHold_q  <= rdActive;
      if (latchEv && hostAck)
      begin
        if (busIn[`HP_OVL_SEL_BIT])
          overlay_q <= busIn[`HP_OVL_MSB:0];
        else
        begin
          addr_q    <= busIn[`HP_ADDR_MSB:0];
          isPm_q    <= busIn[`HP_PM_SEL_BIT];
          lowHalf_q <= 1'b0;
        end
      end
      else if (regWrite && (regAddr == `HP_ADDR_CTRL_OFS) && (state_q == ST_IDLE))
      begin
        if (regWdata[`HP_OVL_SEL_BIT])
          overlay_q <= regWdata[`HP_OVL_MSB:0];
        else
        begin
          addr_q    <= regWdata[`HP_ADDR_MSB:0];
          isPm_q    <= regWdata[`HP_PM_SEL_BIT];
          lowHalf_q <= 1'b0;
        end
      end
      if (regWrite && (regAddr == `HP_TIMING_OFS))
        shortRead_q <= regWdata[`HP_SHORT_READ_BIT];

      if (state_q == ST_SYNC)
      begin
        isRead_q <= !hostReadN;
        if (!isPm_q)
          memWdata <= {8'h00, busIn};
        else if (lowHalf_q)
          memWdata <= {wrHold_q, busIn[7:0]};
        else
          wrHold_q <= busIn;
      end

      if (state_q == ST_ACCESS && needAccess)
      begin
        memStrobe <= 1'b1;
        memAddr   <= addr_q;
        memIsPm   <= isPm_q;
        memWe     <= !isRead_q && !ctrlRegion(isPm_q, addr_q);
      end

      if (state_q == ST_ACCESS && !isRead_q && wordEnd && isPm_q)
      begin
        pmDone_q     <= 1'b1;
        pmDoneAddr_q <= addr_q;
      end

      if (state_q == ST_FINISH && state_d == ST_IDLE)
      begin
        if (wordEnd)
          addr_q <= addr_q + 14'h0001;
        lowHalf_q <= isPm_q && !lowHalf_q;
      end

      if (state_q == ST_ACCESS && isRead_q)
      begin
        if (isPm_q && lowHalf_q)
          busOut <= {8'h00, rdLow_q};
      end
      if (memStrobe && !memWe && isRead_q)
      begin
        rdLow_q <= memRdata[7:0];
        busOut  <= memIsPm ? memRdata[23:8] : memRdata[15:0];
      end
    end
  end

  // ****************************************
  // Core register read
  // ****************************************
  always @*
  begin
    case (regAddr)
      `HP_ADDR_CTRL_OFS: regRdata = {1'b0, isPm_q, addr_q};
      `HP_TIMING_OFS:    regRdata = {1'b0, shortRead_q, 14'h0000};
      default:           regRdata = 16'h0000;
    endcase
  end

  // ****************************************
  // Boot hold
  // ****************************************
  // hold until location zero
  host_boot_hold bootHold
  (
    .clk         (clk),
    .rstn        (rstn),
    .bootMode    (bootMode),
    .pmWriteDone (pmDone_q),
    .pmWriteAddr (pmDoneAddr_q),
    .coreHold    (coreHold)
  );

endmodule // host_dma_port

// File: common/host_port_map.vh
// Constants for the host memory access port: register offsets, fields, modes.
// Assumes a 14-bit data memory address space seen by the core.
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH

// ****************************************
// Register offsets in data memory
// ****************************************
`define HP_ADDR_CTRL_OFS     14'h3fe0
`define HP_TIMING_OFS        14'h3fe7
`define HP_CTRL_REGION_BASE  14'h3fe0

// ****************************************
// Field positions
// ****************************************
`define HP_OVL_SEL_BIT       15
`define HP_PM_SEL_BIT        14
`define HP_SHORT_READ_BIT    14
`define HP_ADDR_MSB          13
`define HP_OVL_MSB           7

// ****************************************
// Reset values and modes
// ****************************************
`define HP_ADDR_RESET        14'h0000
`define HP_OVL_RESET         8'h00
`define HP_SHORT_READ_RESET  1'b0
`define HP_BOOT_MODE_HOST    3'b101
`define HP_READ_HOLD_CYCLES  2'h1

`endif

// File: verilog/host_boot_hold.v
// Holds core execution while code is loaded through the host port.
// Assumes mode inputs are stable around reset release and synchronous to clk.
`timescale 1ns/1ns
`include "host_port_map.vh"

module host_boot_hold
(
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Mode configuration inputs (C, B, A)
  input  wire [2:0]  bootMode,
  // Completed program memory write from the port
  input  wire        pmWriteDone,
  input  wire [13:0] pmWriteAddr,
  // Core hold
  output wire        coreHold
);

  reg captured_q;
  reg hostBoot_q;
  reg released_q;

  // ****************************************
  // Mode capture and release
  // ****************************************
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      captured_q <= 1'b0;
      hostBoot_q <= 1'b0;
      released_q <= 1'b0;
    end
    else
    begin
      if (!captured_q)
      begin
        captured_q <= 1'b1;
        hostBoot_q <= (bootMode == `HP_BOOT_MODE_HOST);
      end
      if (pmWriteDone && (pmWriteAddr == 14'h0000))
        released_q <= 1'b1;
    end
  end

  // Held from reset until the mode is known, then only in host boot.
  assign coreHold = !captured_q || (hostBoot_q && !released_q);

endmodule // host_boot_hold

// File: test/host_dma_port_monitor.sv
// Pin checker for the host memory port.
// Assumes a bind to host_dma_port.
`timescale 1ns/1ns
module host_dma_port_monitor
(
  // Watched ports
  input wire        clk,
  input wire        rstn,
  input wire        portSelectN,
  input wire        addrLatchStrobe,
  input wire        hostReadN,
  input wire        hostWriteN,
  input wire        busOe,
  input wire        hostAck,
  input wire        regWrite,
  input wire        memStrobe,
  input wire        memWe,
  input wire        memIsPm,
  input wire [13:0] memAddr,
  input wire [7:0]  overlaySel,
  input wire        coreHold
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sBusy;
    !hostAck ##1 !hostAck ##1 hostAck;
  endsequence
  a_ack_busy_two: assert property ($fell(hostAck) |-> sBusy)
    else $error("ack low span wrong");
  a_ack_low_cause: assert property ($fell(hostAck) |->
    $past(!portSelectN && (!hostReadN || !hostWriteN)))
    else $error("ack fell without request");
  a_strobe_at_done: assert property (memStrobe |-> $rose(hostAck))
    else $error("strobe outside finish");
  a_strobe_one_cycle: assert property (memStrobe |=> !memStrobe)
    else $error("strobe too long");
  a_ctrl_area_safe: assert property (memStrobe && memWe && !memIsPm |->
    memAddr < 14'h3fe0)
    else $error("control area written");
  a_hold_stays_off: assert property (!coreHold |=> !coreHold)
    else $error("hold came back");
  a_oe_with_read: assert property (busOe |-> !hostReadN || $past(!hostReadN))
    else $error("bus driven without read");
  a_ovl_by_latch: assert property ($changed(overlaySel) |->
    $past(regWrite) || $past(addrLatchStrobe, 2))
    else $error("overlay changed alone");
endmodule // host_dma_port_monitor

bind host_dma_port host_dma_port_monitor uMon (.clk(clk), .rstn(rstn),
  .portSelectN(portSelectN), .addrLatchStrobe(addrLatchStrobe), .hostReadN(hostReadN),
  .hostWriteN(hostWriteN), .busOe(busOe), .hostAck(hostAck), .regWrite(regWrite),
  .memStrobe(memStrobe), .memWe(memWe), .memIsPm(memIsPm), .memAddr(memAddr),
  .overlaySel(overlaySel), .coreHold(coreHold));

// File: test/host_model.sv
// Host processor model for the port pins.
// Assumes pins change on the falling clock edge.
`timescale 1ns/1ns
module host_model
(
  // Clock and answer
  input  wire        clk,
  input  wire        hostAck,
  input  wire [15:0] busOut,
  // Driven pins
  output reg         portSelectN,
  output reg         addrLatchStrobe,
  output reg         hostReadN,
  output reg         hostWriteN,
  output reg  [15:0] busIn
);
  initial
  begin
    portSelectN = 1'b1;
    addrLatchStrobe = 1'b0;
    hostReadN = 1'b1;
    hostWriteN = 1'b1;
    busIn = 16'h0000;
  end
  task waitAck;
    integer n;
    begin
      n = 0;
      while (hostAck !== 1'b1 && n < 20)
      begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task latch(input [15:0] w);
    begin
      waitAck;
      portSelectN = 1'b0;
      addrLatchStrobe = 1'b1;
      busIn = w;
      @(negedge clk);
      addrLatchStrobe = 1'b0;
      @(negedge clk);
      portSelectN = 1'b1;
      busIn = ~w;
      @(negedge clk);
    end
  endtask
  task xfer(input wr, input [15:0] d, output [15:0] q);
    begin
      waitAck;
      portSelectN = 1'b0;
      hostWriteN = !wr;
      hostReadN = wr;
      busIn = d;
      repeat (2) @(negedge clk);
      waitAck;
      @(negedge clk);
      q = busOut;
      portSelectN = 1'b1;
      hostWriteN = 1'b1;
      hostReadN = 1'b1;
      busIn = ~d;
      @(negedge clk);
    end
  endtask
endmodule // host_model

// File: test/host_dma_port_tb.sv
// Testbench for the host memory port.
// Assumes host_model on the pins and a flat array as memory.
`timescale 1ns/1ns
module host_dma_port_tb;
  reg         clk;
  reg         rstn;
  reg         regWrite;
  reg  [13:0] regAddr;
  reg  [15:0] regWdata;
  wire [15:0] busIn, busOut, regRdata;
  wire        selN, als, rdN, wrN, busOe, hostAck;
  wire        memStrobe, memWe, memIsPm, coreHold;
  wire [13:0] memAddr;
  wire [23:0] memWdata;
  wire [7:0]  overlaySel;
  reg  [2:0]  bootMode;
  reg  [23:0] mem [0:32767];
  reg  [15:0] q;
  wire [23:0] memRdata;
  reg  [23:0] oeMark;
  reg  [23:0] oeLate = 24'h000000;
  integer     errCount, checksDone;
  host_model hostM (.clk(clk), .hostAck(hostAck), .busOut(busOut), .portSelectN(selN),
    .addrLatchStrobe(als), .hostReadN(rdN), .hostWriteN(wrN), .busIn(busIn));
  host_dma_port uut (.clk(clk), .rstn(rstn), .portSelectN(selN), .addrLatchStrobe(als),
    .hostReadN(rdN), .hostWriteN(wrN), .busIn(busIn), .busOut(busOut), .busOe(busOe),
    .hostAck(hostAck), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .memStrobe(memStrobe), .memWe(memWe), .memIsPm(memIsPm),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .overlaySel(overlaySel), .bootMode(bootMode), .coreHold(coreHold));
  assign memRdata = mem[{memIsPm, memAddr}];
  // Counts cycles in which the bus is still driven after the read strobe went high.
  always @(posedge clk)
    if (busOe === 1'b1 && rdN === 1'b1)
      oeLate <= oeLate + 24'h000001;
  always @(posedge clk)
    if (memStrobe && memWe)
      mem[{memIsPm, memAddr}] <= memWdata;
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input [23:0] got, input [23:0] exp);
    begin
      checksDone = checksDone + 1;
      if (got !== exp)
      begin
        errCount = errCount + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task regWr(input [13:0] a, input [15:0] d);
    begin
      regWrite = 1'b1;
      regAddr = a;
      regWdata = d;
      @(negedge clk);
      regWrite = 1'b0;
    end
  endtask
  task testDone;
    begin
      $display("checks %0d errors %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task tData;
    begin
      hostM.latch(16'h0010);
      hostM.xfer(1'b1, 16'h1234, q);
      hostM.xfer(1'b1, 16'h5678, q);
      chk(mem[15'h0010], 24'h1234);
      chk(mem[15'h0011], 24'h5678);
      hostM.latch(16'h0010);
      oeMark = oeLate;
      hostM.xfer(1'b0, 16'h0000, q);
      chk({8'h00, q}, 24'h1234);
      chk(oeLate - oeMark, 24'h000001);
      hostM.xfer(1'b0, 16'h0000, q);
      chk({8'h00, q}, 24'h5678);
      hostM.latch(16'h4020);
      hostM.xfer(1'b1, 16'habcd, q);
      hostM.xfer(1'b1, 16'h00ef, q);
      chk(mem[15'h4020], 24'habcdef);
      chk({23'h0, coreHold}, 24'h1);
      hostM.latch(16'h4020);
      hostM.xfer(1'b0, 16'h0000, q);
      chk({8'h00, q}, 24'habcd);
      hostM.xfer(1'b0, 16'h0000, q);
      chk({8'h00, q}, 24'h00ef);
      $display("data test done");
    end
  endtask
  task tCtrl;
    begin
      mem[15'h3fe0] = 24'h0;
      mem[15'h0034] = 24'h005a5a;
      hostM.latch(16'h3fe0);
      hostM.xfer(1'b1, 16'h1111, q);
      chk(mem[15'h3fe0], 24'h0);
      regWr(14'h3fe0, 16'h8005);
      chk({16'h0, overlaySel}, 24'h05);
      hostM.latch(16'h8000);
      chk({16'h0, overlaySel}, 24'h00);
      chk({8'h00, regRdata}, 24'h3fe1);
      regWr(14'h3fe0, 16'h0033);
      chk({8'h00, regRdata}, 24'h0033);
      hostM.xfer(1'b1, 16'h00aa, q);
      chk(mem[15'h0033], 24'h00aa);
      regWr(14'h3fe7, 16'h4000);
      chk({8'h00, regRdata}, 24'h4000);
      oeMark = oeLate;
      hostM.xfer(1'b0, 16'h0000, q);
      chk(oeLate - oeMark, 24'h000000);
      chk({8'h00, q}, 24'h5a5a);
      regWr(14'h3fe5, 16'h0000);
      chk({8'h00, regRdata}, 24'h0);
      hostM.latch(16'h4000);
      hostM.xfer(1'b1, 16'h0000, q);
      hostM.xfer(1'b1, 16'h0000, q);
      chk({23'h0, coreHold}, 24'h0);
      $display("control test done");
    end
  endtask
  task tBoot;
    begin
      bootMode = 3'h0;
      regAddr = 14'h3fe7;
      rstn = 1'b0;
      repeat (3) @(negedge clk);
      chk({21'h0, busOe, hostAck, coreHold}, 24'h3);
      rstn = 1'b1;
      repeat (2) @(negedge clk);
      chk({22'h0, hostAck, coreHold}, 24'h2);
      chk({8'h00, regRdata}, 24'h0);
      hostM.latch(16'h0040);
      hostM.xfer(1'b1, 16'h0bee, q);
      chk(mem[15'h0040], 24'h000bee);
      $display("boot test done");
    end
  endtask
  initial
  begin
    errCount = 0;
    checksDone = 0;
    bootMode = 3'h5;
    rstn = 1'b0;
    regWrite = 1'b0;
    regAddr = 14'h3fe0;
    regWdata = 16'h0000;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk({22'h0, hostAck, coreHold}, 24'h3);
    chk({8'h00, regRdata}, 24'h0);
    tData;
    tCtrl;
    tBoot;
    testDone;
  end
  initial
  begin
    #60000;
    errCount = errCount + 1;
    testDone;
  end
endmodule // host_dma_port_tb
